// ### pipelined_zero_turnaround_sram_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pipelined_zero_turnaround_sram_port_tb;
    import sram_port_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic reqValid = 1'b0, reqStep = 1'b0, reqWrite = 1'b0, reqSelect = 1'b0;
    logic [ADDR_W-1:0] reqAddr = ADDR_RST;
    logic [LANES-1:0] reqLanes = 4'hf;
    logic [DATA_W-1:0] reqData = DATA_RST;
    logic interleaveSel = 1'b0;
    logic rspValid;
    logic [DATA_W-1:0] rspData;
    logic [31:0] lfsr = 32'haa76;
    logic [DATA_W-1:0] model [int];
    logic [DATA_W-1:0] expQ [$];
    logic [ADDR_W-1:0] aList [$];
    logic [ADDR_W-1:0] base, a;
    logic [1:0] cnt;
    logic curWrite, curSel;
    int nMismatch = 0, nTests = 0, nReads = 0, nRsp = 0, cycles = 0;
    sram_port_if bus ();
    always #5 mclk = ~mclk;
    sram_port_device u_sram_port_device (.mclk, .rstn, .bus(bus));
    sram_port_host u_sram_port_host (.mclk, .rstn, .reqValid, .reqStep,
        .reqWrite, .reqSelect, .reqAddr, .reqLanes, .reqData, .interleaveSel,
        .rspValid, .rspData, .bus(bus));
    sram_port_monitor u_sram_port_monitor (.mclk, .rstn,
        .burstStepOrLoad(bus.burstStepOrLoad), .writeStrobeN(bus.writeStrobeN),
        .chipSelN(bus.chipSelN), .chipSelectPair(bus.chipSelectPair),
        .chipSelPairN(bus.chipSelPairN), .clockGateN(bus.clockGateN),
        .outputDriveEnN(bus.outputDriveEnN), .ctlDataOe(bus.ctlDataOe),
        .memDataOe(bus.memDataOe));
    function automatic logic [31:0] nextRand(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [ADDR_W-1:0] effAddr(input logic [ADDR_W-1:0] b,
        input logic [1:0] c, input logic il);
        return {b[ADDR_W-1:2], il ? (b[1:0] ^ c) : 2'(b[1:0] + c)};
    endfunction
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
        input logic [DATA_W-1:0] n, input logic [LANES-1:0] ln);
        for (int l = 0; l < LANES; l++) begin
            if (ln[l]) o[l*LANE_W +: LANE_W] = n[l*LANE_W +: LANE_W];
        end
        return o;
    endfunction
    task automatic chkData(input logic [DATA_W-1:0] got, exp);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkCount(input logic [31:0] got, exp);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // the model follows the burst itself, so steps need no address
    task automatic issue(input logic st, wr, sl, input logic [ADDR_W-1:0] ad,
        input logic [LANES-1:0] ln, input logic [DATA_W-1:0] d);
        logic [ADDR_W-1:0] ea;
        @(posedge mclk);
        #1;
        reqValid = 1'b1;
        reqStep = st;
        reqWrite = wr;
        reqSelect = sl;
        reqAddr = ad;
        reqLanes = ln;
        reqData = d;
        if (!st) begin
            base = ad;
            cnt = 2'h0;
            curWrite = wr;
            curSel = sl;
        end else begin
            cnt = cnt + 2'h1;
        end
        ea = effAddr(base, cnt, interleaveSel);
        if (curSel && curWrite) begin
            model[ea] = merge(model.exists(ea) ? model[ea] : 'x, d, ln);
        end else if (curSel) begin
            expQ.push_back(model[ea]);
            nReads++;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) issue(1'b0, 1'b0, 1'b0, ADDR_RST, 4'hf, DATA_RST);
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            nMismatch++;
            completeRun();
        end
        if (rspValid === 1'b1) begin
            nRsp++;
            if (expQ.size() == 0) chkCount(32'h0, 32'h1);
            else chkData(rspData, expQ.pop_front());
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        #1 rstn = 1'b1;
        // burst written from one seed, read from another, both orders
        for (int il = 0; il < 2; il++) begin
            idle(8);
            interleaveSel = il[0];
            idle(8);
            lfsr = nextRand(lfsr);
            a = {1'b0, lfsr[16:0]};
            aList.push_back(a);
            for (int i = 0; i < 4; i++) begin
                lfsr = nextRand(lfsr);
                issue(i != 0, 1'b1, 1'b1, a, 4'hf, {lfsr[3:0], lfsr});
            end
            idle(8);
            for (int i = 0; i < 4; i++) issue(i != 0, 1'b0, 1'b1, a ^ 18'h3, 4'hf, 0);
        end
        for (int k = 0; k < 16; k++) issue(0, 1, 1, 18'h20000 + k, 4'hf, k * 5);
        // random mix, back to back, partial lanes and deselected writes
        for (int i = 0; i < 48; i++) begin
            lfsr = nextRand(lfsr);
            a = {1'b1, 13'h0, lfsr[5:2]};
            case (lfsr[1:0])
                2'h0: issue(0, 1, 1, a, lfsr[9:6], {lfsr[3:0], lfsr});
                2'h2: issue(0, 1, 0, a, 4'hf, {lfsr[3:0], lfsr});
                default: issue(0, 0, 1, aList[lfsr[2]] ^ lfsr[4:3], 4'hf, 0);
            endcase
        end
        idle(12);
        @(posedge mclk);
        #1 reqValid = 1'b0;
        repeat (6) @(posedge mclk);
        for (int k = 0; k < 16; k++) issue(0, 0, 1, 18'h20000 + k, 4'hf, 0);
        idle(16);
        chkCount(nRsp, nReads);
        completeRun();
    end
endmodule
`default_nettype wire

// ### sram_port_device.sv
`timescale 1ns/10ps
`default_nettype none
module sram_port_device
    import sram_port_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // memory pins
    sram_port_if.device bus
);
    // input registers, first and second sync stages
    logic [ADDR_W-1:0] addrS1_ff, addrS2_ff;
    logic loadNS1_ff, loadNS2_ff;
    logic weNS1_ff, weNS2_ff;
    logic [LANES-1:0] bwNS1_ff, bwNS2_ff;
    logic [2:0] csS1_ff, csS2_ff;
    logic gateNS1_ff, gateNS2_ff;
    logic oeNS1_ff, oeNS2_ff;
    logic modeS1_ff, modeS2_ff;
    logic [DATA_W-1:0] dS1_ff, dS2_ff;

    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] base_ff;
    logic [SEED_W-1:0] cnt_ff;
    op_e op_ff;
    // two-stage pipe of pending operations
    op_e pipeOp_ff [DATA_LAG];
    logic [ADDR_W-1:0] pipeAddr_ff [DATA_LAG];
    logic [LANES-1:0] pipeBw_ff [DATA_LAG];
    logic [DATA_W-1:0] rdData_ff;
    logic rdOe_ff;
    // write data comes back at the read lag, after its own sync stages
    localparam int WR_LAG = DATA_LAG + 1;
    logic wrDue_ff [WR_LAG];
    logic [ADDR_W-1:0] wrAddr_ff [WR_LAG];
    logic [LANES-1:0] wrBw_ff [WR_LAG];

    logic enable;
    logic selected;
    op_e nxt_op;
    logic [SEED_W-1:0] nxt_cnt;
    logic [ADDR_W-1:0] curAddr;

    // pins come from outside the domain
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            addrS1_ff <= ADDR_RST;
            addrS2_ff <= ADDR_RST;
            loadNS1_ff <= 1'b1;
            loadNS2_ff <= 1'b1;
            weNS1_ff <= 1'b1;
            weNS2_ff <= 1'b1;
            bwNS1_ff <= LANES_OFF;
            bwNS2_ff <= LANES_OFF;
            csS1_ff <= 3'h0;
            csS2_ff <= 3'h0;
            gateNS1_ff <= 1'b1;
            gateNS2_ff <= 1'b1;
            oeNS1_ff <= 1'b1;
            oeNS2_ff <= 1'b1;
            modeS1_ff <= 1'b0;
            modeS2_ff <= 1'b0;
            dS1_ff <= DATA_RST;
            dS2_ff <= DATA_RST;
        end else begin
            addrS1_ff <= bus.addr;
            addrS2_ff <= addrS1_ff;
            loadNS1_ff <= bus.burstStepOrLoad;
            loadNS2_ff <= loadNS1_ff;
            weNS1_ff <= bus.writeStrobeN;
            weNS2_ff <= weNS1_ff;
            bwNS1_ff <= bus.byteLaneWriteN;
            bwNS2_ff <= bwNS1_ff;
            csS1_ff <= {~bus.chipSelN, bus.chipSelectPair,
                        ~bus.chipSelPairN};
            csS2_ff <= csS1_ff;
            gateNS1_ff <= bus.clockGateN;
            gateNS2_ff <= gateNS1_ff;
            oeNS1_ff <= bus.outputDriveEnN;
            oeNS2_ff <= oeNS1_ff;
            modeS1_ff <= bus.burstOrderSel;
            modeS2_ff <= modeS1_ff;
            dS1_ff <= bus.dataLane;
            dS2_ff <= dS1_ff;
        end
    end

    assign enable = !gateNS2_ff;
    assign selected = &csS2_ff;

    // load or step; a step keeps the loaded operation type
    always_comb begin
        nxt_op = op_ff;
        nxt_cnt = cnt_ff;
        if (!loadNS2_ff) begin
            nxt_cnt = SEED_RST;
            if (!selected)
                nxt_op = OP_DESEL;
            else if (!weNS2_ff)
                nxt_op = OP_WRITE;
            else
                nxt_op = OP_READ;
        end else begin
            nxt_cnt = SEED_W'(cnt_ff + 2'h1);
        end
    end

    // wraps after four steps by width alone
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            base_ff <= ADDR_RST;
            cnt_ff <= SEED_RST;
            op_ff <= OP_DESEL;
        end else if (enable) begin
            if (!loadNS2_ff)
                base_ff <= addrS2_ff;
            cnt_ff <= nxt_cnt;
            op_ff <= nxt_op;
        end
    end

    // address of the access issued this enabled cycle
    always_comb begin
        curAddr = !loadNS2_ff ? addrS2_ff : base_ff;
        curAddr[SEED_W-1:0] = burstAddr(curAddr[SEED_W-1:0],
            !loadNS2_ff ? SEED_RST : nxt_cnt, modeS2_ff);
    end

    // pipe advances only on enabled cycles, so data keeps its lag
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DATA_LAG; i++) begin
                pipeOp_ff[i] <= OP_DESEL;
                pipeAddr_ff[i] <= ADDR_RST;
                pipeBw_ff[i] <= LANES_OFF;
            end
        end else if (enable) begin
            pipeOp_ff[0] <= nxt_op;
            pipeAddr_ff[0] <= curAddr;
            pipeBw_ff[0] <= bwNS2_ff;
            for (int i = 1; i < DATA_LAG; i++) begin
                pipeOp_ff[i] <= pipeOp_ff[i-1];
                pipeAddr_ff[i] <= pipeAddr_ff[i-1];
                pipeBw_ff[i] <= pipeBw_ff[i-1];
            end
        end
    end

    // hold a write until its synced data is in hand
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < WR_LAG; i++) begin
                wrDue_ff[i] <= 1'b0;
                wrAddr_ff[i] <= ADDR_RST;
                wrBw_ff[i] <= LANES_OFF;
            end
        end else if (enable) begin
            wrDue_ff[0] <= pipeOp_ff[DATA_LAG-1] == OP_WRITE;
            wrAddr_ff[0] <= pipeAddr_ff[DATA_LAG-1];
            wrBw_ff[0] <= pipeBw_ff[DATA_LAG-1];
            for (int i = 1; i < WR_LAG; i++) begin
                wrDue_ff[i] <= wrDue_ff[i-1];
                wrAddr_ff[i] <= wrAddr_ff[i-1];
                wrBw_ff[i] <= wrBw_ff[i-1];
            end
        end
    end

    // array write, self-timed, lane by lane; no reset on the array
    always_ff @(posedge mclk) begin
        if (enable && wrDue_ff[WR_LAG-1]) begin
            for (int l = 0; l < LANES; l++) begin
                if (!wrBw_ff[WR_LAG-1][l])
                    mem[wrAddr_ff[WR_LAG-1]][l*LANE_W +: LANE_W]
                        <= dS2_ff[l*LANE_W +: LANE_W];
            end
        end
    end

    // read data and bus drive
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdData_ff <= DATA_RST;
            rdOe_ff <= 1'b0;
        end else begin
            if (enable && pipeOp_ff[DATA_LAG-2+1] == OP_READ)
                rdData_ff <= mem[pipeAddr_ff[DATA_LAG-1]];
            if (enable)
                rdOe_ff <= pipeOp_ff[DATA_LAG-1] == OP_READ;
        end
    end

    assign bus.memDataOut = rdData_ff;
    assign bus.memDataOe = rdOe_ff && !oeNS2_ff;
endmodule
`default_nettype wire

// ### sram_port_host.sv
// controller end: issues one access per request
`timescale 1ns/10ps
`default_nettype none
module sram_port_host
    import sram_port_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // user request
    input wire logic reqValid,
    input wire logic reqStep,
    input wire logic reqWrite,
    input wire logic reqSelect,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [LANES-1:0] reqLanes,
    input wire logic [DATA_W-1:0] reqData,
    input wire logic interleaveSel,
    // user answer
    output logic rspValid,
    output logic [DATA_W-1:0] rspData,
    // memory pins
    sram_port_if.host bus
);
    // request to host data sample: pins, two sync, two pipe, drive, two
    localparam int LAG = DATA_LAG + 6;
    logic [ADDR_W-1:0] addr_ff;
    logic loadN_ff, weN_ff, csN_ff, gateN_ff, oeN_ff, mode_ff;
    logic [LANES-1:0] bwN_ff;
    logic [LAG-1:0] wrPipe_ff, rdPipe_ff;
    logic [DATA_W-1:0] wrData_ff [LAG];
    logic [DATA_W-1:0] d1_ff, d2_ff, ctlOut_ff;
    logic ctlOe_ff, rspValid_ff;
    logic [DATA_W-1:0] rspData_ff;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            addr_ff <= ADDR_RST;
            loadN_ff <= 1'b1;
            weN_ff <= 1'b1;
            csN_ff <= 1'b1;
            bwN_ff <= LANES_OFF;
            gateN_ff <= 1'b1;
            oeN_ff <= 1'b1;
            mode_ff <= 1'b0;
        end else begin
            gateN_ff <= !reqValid;
            oeN_ff <= !reqValid;
            mode_ff <= interleaveSel;
            addr_ff <= reqAddr;
            loadN_ff <= reqStep;
            weN_ff <= !reqWrite;
            csN_ff <= !reqSelect;
            bwN_ff <= ~reqLanes;
        end
    end

    // track when own write data is due and when read data returns
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPipe_ff <= '0;
            rdPipe_ff <= '0;
            for (int i = 0; i < LAG; i++)
                wrData_ff[i] <= DATA_RST;
        end else if (reqValid) begin
            wrPipe_ff <= {wrPipe_ff[LAG-2:0], reqValid && reqWrite};
            rdPipe_ff <= {rdPipe_ff[LAG-2:0],
                          reqValid && !reqWrite && reqSelect};
            wrData_ff[0] <= reqData;
            for (int i = 1; i < LAG; i++)
                wrData_ff[i] <= wrData_ff[i-1];
        end
    end

    // drive bus only when write data due
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctlOut_ff <= DATA_RST;
            ctlOe_ff <= 1'b0;
            d1_ff <= DATA_RST;
            d2_ff <= DATA_RST;
            rspValid_ff <= 1'b0;
            rspData_ff <= DATA_RST;
        end else begin
            ctlOe_ff <= wrPipe_ff[LAG-4];
            ctlOut_ff <= wrData_ff[LAG-4];
            d1_ff <= bus.dataLane;
            d2_ff <= d1_ff;
            rspValid_ff <= rdPipe_ff[LAG-1] && reqValid;
            rspData_ff <= d2_ff;
        end
    end

    assign bus.addr = addr_ff;
    assign bus.burstStepOrLoad = loadN_ff;
    assign bus.writeStrobeN = weN_ff;
    assign bus.byteLaneWriteN = bwN_ff;
    assign bus.chipSelN = csN_ff;
    assign bus.chipSelectPair = !csN_ff;
    assign bus.chipSelPairN = csN_ff;
    assign bus.clockGateN = gateN_ff;
    assign bus.outputDriveEnN = oeN_ff;
    assign bus.burstOrderSel = mode_ff;
    assign bus.sleepRequest = 1'b0;
    assign bus.ctlDataOut = ctlOut_ff;
    assign bus.ctlDataOe = ctlOe_ff;
    assign rspValid = rspValid_ff;
    assign rspData = rspData_ff;
endmodule
`default_nettype wire

// ### sram_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sram_port_if;
    import sram_port_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic burstStepOrLoad;
    logic writeStrobeN;
    logic [LANES-1:0] byteLaneWriteN;
    logic chipSelN;
    logic chipSelectPair;
    logic chipSelPairN;
    logic clockGateN;
    logic outputDriveEnN;
    logic burstOrderSel;
    logic sleepRequest;
    logic [DATA_W-1:0] ctlDataOut;
    logic ctlDataOe;
    logic [DATA_W-1:0] memDataOut;
    logic memDataOe;
    logic [DATA_W-1:0] dataLane;

    // shared bus resolved from the two enables
    assign dataLane = ctlDataOe ? ctlDataOut :
                      memDataOe ? memDataOut : DATA_RST;

    modport device (
        input addr, burstStepOrLoad, writeStrobeN, byteLaneWriteN,
        input chipSelN, chipSelectPair, chipSelPairN, clockGateN,
        input outputDriveEnN, burstOrderSel, sleepRequest, dataLane,
        output memDataOut, memDataOe
    );
    modport host (
        output addr, burstStepOrLoad, writeStrobeN, byteLaneWriteN,
        output chipSelN, chipSelectPair, chipSelPairN, clockGateN,
        output outputDriveEnN, burstOrderSel, sleepRequest,
        output ctlDataOut, ctlDataOe,
        input dataLane
    );
endinterface
`default_nettype wire

// ### sram_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sram_port_monitor
    import sram_port_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // pins
    input wire logic burstStepOrLoad,
    input wire logic writeStrobeN,
    input wire logic chipSelN,
    input wire logic chipSelectPair,
    input wire logic chipSelPairN,
    input wire logic clockGateN,
    input wire logic outputDriveEnN,
    input wire logic ctlDataOe,
    input wire logic memDataOe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    logic sel;
    logic readLoad;
    logic writeLoad;
    logic [3:0] quietCnt_ff;
    assign sel = !chipSelN && chipSelectPair && !chipSelPairN;
    assign readLoad = !clockGateN && !burstStepOrLoad && sel && writeStrobeN;
    assign writeLoad = !clockGateN && !burstStepOrLoad && sel && !writeStrobeN;
    // held while gated, since the device pipeline is frozen as well
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            quietCnt_ff <= 4'h0;
        end else if (clockGateN) begin
            quietCnt_ff <= quietCnt_ff;
        end else if (burstStepOrLoad || readLoad) begin
            quietCnt_ff <= 4'h0;
        end else if (quietCnt_ff != 4'hf) begin
            quietCnt_ff <= quietCnt_ff + 4'h1;
        end
    end
    bus_contention_a: assert property (!(ctlDataOe && memDataOe))
        else $error("both ends drive the data bus");
    read_drive_a: assert property (readLoad |-> ##[2:8] memDataOe)
        else $error("read data not driven in time");
    write_data_a: assert property (writeLoad |-> ##[2:8] ctlDataOe)
        else $error("write data not driven in time");
    turnaround_a: assert property (
        readLoad ##1 writeLoad |-> ##[2:8] (memDataOe ##[1:4] ctlDataOe))
        else $error("read then write not served back to back");
    output_release_a: assert property (outputDriveEnN [*5] |-> !memDataOe)
        else $error("data driven while output enable is off");
    stray_drive_a: assert property (memDataOe |-> quietCnt_ff <= 4'h8)
        else $error("data driven with no read due");
    gate_freeze_a: assert property (clockGateN [*4] |=> $stable(memDataOe))
        else $error("device moved while clock gated");
    reset_idle_a: assert property ($past(!rstn) |->
        writeStrobeN && clockGateN && !memDataOe && !ctlDataOe)
        else $error("pins not idle after reset");
endmodule
`default_nettype wire

// ### sram_port_pkg.sv
package sram_port_pkg;
    // wide organisation: 256K words of 36 bits, four 9-bit lanes
    localparam int ADDR_W = 18;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DEPTH = 262144;
    localparam int SEED_W = 2;
    // cycles from address load to data on the bus
    localparam int DATA_LAG = 2;
    localparam logic [SEED_W-1:0] SEED_RST = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
    localparam logic [LANES-1:0] LANES_OFF = 4'hf;

    typedef enum logic [1:0] {
        OP_DESEL,
        OP_READ,
        OP_WRITE
    } op_e;

    // burst address of step number cnt from the loaded seed
    function automatic logic [SEED_W-1:0] burstAddr(
        input logic [SEED_W-1:0] seed,
        input logic [SEED_W-1:0] cnt,
        input logic interleaved
    );
        burstAddr = interleaved ? (seed ^ cnt) : SEED_W'(seed + cnt);
    endfunction
endpackage
